// ### vdr_pkg.sv
// Constants and carrier types for the serial register access port.
// Assumes one system clock domain; bus pins are sampled, not clocked on.
package vdr_pkg;
  localparam logic [6:0] VDR_ADDR_STRAP_LO = 7'h5c;  // Byte B8h/B9h
  localparam logic [6:0] VDR_ADDR_STRAP_HI = 7'h5d;  // Byte BAh/BBh
  localparam logic [7:0] VDR_LONG_WAIT_TOP = 8'h8f;
  localparam int         VDR_WAIT_US       = 64;
  localparam int         VDR_CLK_MHZ       = 25;
  localparam int         VDR_WAIT_CYC      = VDR_WAIT_US * VDR_CLK_MHZ;
  localparam logic [7:0] VDR_SUBADDR_RST   = 8'h00;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } vdr_reg_req_s;
endpackage : vdr_pkg

// ### vdr_i2c_slave.sv
// Serial register access slave: address match, subaddress, reads and writes.
// Assumes the register array answers rdData combinationally; the port owns it here.
`timescale 1ns/1ps
`default_nettype none
module vdr_i2c_slave #(
  parameter int WAIT_CYC = vdr_pkg::VDR_WAIT_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  sclIn,
  output logic                       sclOut,
  output logic                       sclOe,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  input  wire logic                  busAddressSelectStrap,
  input  wire logic                  refClkLocked,
  output vdr_pkg::vdr_reg_req_s      regReq,
  output logic                       regReqValid,
  output logic                       busy
);
  import vdr_pkg::*;

  typedef enum {IDLE, ADDR, ACK, WDATA, RDATA, RACK, SKIP} vdr_state_e;

  logic [1:0] sclSync, sdaSync;
  logic       sclD, sdaD;
  logic [7:0] regs [256];
  logic [7:0] shift_r, subAddr_r;
  logic [3:0] bitCnt_r;
  logic       strap_r, strapTaken_r, rnw_r, gotSub_r, ackDrive_r;
  logic [6:0] myAddr;
  logic [$clog2(WAIT_CYC+1)-1:0] waitCnt_r;
  logic [1:0] phase_r;
  vdr_state_e state_r;
  logic sclRise, sclFall, startCond, stopCond;
  logic [1:0] strapSync_r, lockSync_r, warm_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclD    <= 1'b1;
      sdaD    <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclD    <= sclSync[1];
      sdaD    <= sdaSync[1];
    end
  end

  assign sclRise = sclSync[1] & ~sclD;
  assign sclFall = ~sclSync[1] & sclD;
  assign startCond = sclSync[1] & sclD & sdaD & ~sdaSync[1];
  assign stopCond  = sclSync[1] & sclD & ~sdaD & sdaSync[1];

  // Strap pin and PLL lock come from outside this clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapSync_r <= 2'h0;
      lockSync_r  <= 2'h0;
      warm_r      <= 2'h0;
    end else begin
      strapSync_r <= {strapSync_r[0], busAddressSelectStrap};
      lockSync_r  <= {lockSync_r[0], refClkLocked};
      warm_r      <= {warm_r[0], 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_r      <= 1'b0;
      strapTaken_r <= 1'b0;
    end else if (!strapTaken_r && warm_r[1]) begin
      strap_r      <= strapSync_r[1];
      strapTaken_r <= 1'b1;
    end
  end

  assign myAddr = strap_r ? VDR_ADDR_STRAP_HI : VDR_ADDR_STRAP_LO;

  // Clock is stretched during the low half of the ack bit after a data byte written to subaddress 8Fh or below
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r <= '0;
    end else if (state_r == WDATA && bitCnt_r == 4'h8 && sclFall && gotSub_r &&
                 subAddr_r <= VDR_LONG_WAIT_TOP) begin
      waitCnt_r <= ($clog2(WAIT_CYC+1))'(WAIT_CYC);
    end else if (waitCnt_r != '0) begin
      waitCnt_r <= waitCnt_r - 1'b1;
    end
  end

  // hold clock low while busy or PLL not ready
  assign busy   = (waitCnt_r != '0) | ~lockSync_r[1];
  assign sclOut = 1'b0;
  // Own transfers only; never stall a transfer meant for another device
  assign sclOe  = busy & ~sclSync[1] & (state_r inside {ACK, WDATA, RDATA, RACK});

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= IDLE;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      rnw_r      <= 1'b0;
      gotSub_r   <= 1'b0;
      ackDrive_r <= 1'b0;
      phase_r    <= 2'h0;
    end else if (stopCond) begin
      state_r    <= IDLE;
      ackDrive_r <= 1'b0;
    end else if (startCond) begin
      state_r    <= ADDR;
      bitCnt_r   <= 4'h0;
      ackDrive_r <= 1'b0;
    end else if (sclRise) begin
      unique case (state_r)
        ADDR, WDATA: begin
          if (bitCnt_r < 4'h8) begin
            shift_r  <= {shift_r[6:0], sdaSync[1]};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
        end
        RDATA: begin
          bitCnt_r <= bitCnt_r + 4'h1;
        end
        RACK: begin
          // master nack ends the byte stream
          state_r  <= sdaSync[1] ? SKIP : RDATA;
          bitCnt_r <= 4'h0;
        end
        ACK, IDLE, SKIP: begin
        end
      endcase
    end else if (sclFall) begin
      unique case (state_r)
        ADDR: begin
          if (bitCnt_r == 4'h8) begin
            if (shift_r[7:1] == myAddr) begin
              rnw_r      <= shift_r[0];
              gotSub_r   <= 1'b0;
              ackDrive_r <= 1'b1;
              state_r    <= ACK;
            end else begin
              state_r <= SKIP;
            end
          end
        end
        WDATA: begin
          if (bitCnt_r == 4'h8) begin
            ackDrive_r <= 1'b1;
            gotSub_r   <= 1'b1;
            state_r    <= ACK;
          end
        end
        ACK: begin
          ackDrive_r <= 1'b0;
          bitCnt_r   <= 4'h0;
          state_r    <= rnw_r ? RDATA : WDATA;
        end
        RDATA: begin
          if (bitCnt_r == 4'h8) begin
            state_r <= RACK;
          end
        end
        RACK, IDLE, SKIP: begin
        end
      endcase
    end
  end

  // subaddress kept across stop; auto-increment per byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      subAddr_r <= VDR_SUBADDR_RST;
    end else if (state_r == WDATA && bitCnt_r == 4'h8 && sclFall) begin
      // Subaddress byte loads; a data byte steps it on the same edge that regReq takes the old address
      subAddr_r <= gotSub_r ? subAddr_r + 8'h01 : shift_r;
    end else if (state_r == RACK && sclRise) begin
      subAddr_r <= subAddr_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regReqValid <= 1'b0;
      regReq      <= '0;
    end else begin
      regReqValid <= state_r == WDATA && bitCnt_r == 4'h8 && sclFall && gotSub_r;
      regReq      <= '{wrEn: 1'b1, addr: subAddr_r, data: shift_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (regReqValid) begin
      regs[regReq.addr] <= regReq.data;
    end
  end

  // MSB-first read data, output only changes with clock low
  logic readBit;
  assign readBit = regs[subAddr_r][3'(4'h7 - bitCnt_r)];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOe <= 1'b0;
    end else if (!sclSync[1]) begin
      sdaOe <= ackDrive_r | (state_r == RDATA && bitCnt_r < 4'h8 && !readBit);
    end
  end
  assign sdaOut = 1'b0;

  strap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $past(strapTaken_r) |-> $stable(strap_r)) else $error("strap changed");
  stretch_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sclOe |-> busy) else $error("stretch without cause");
  read_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == RACK && sclRise && !stopCond && !startCond) |=>
      subAddr_r == $past(subAddr_r) + 8'h01) else $error("no address step");
  sub_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == WDATA && bitCnt_r == 4'h8 && sclFall && !stopCond && !startCond)
      |=> ackDrive_r) else $error("subaddress not acked");
  stop_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stopCond |=> state_r == IDLE) else $error("stop missed");
  // our data only moves with clock low
  sequence sclHeldHigh;
    sclSync[1] && sclD;
  endsequence
  sda_steady_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sclHeldHigh |-> $stable(sdaOe)) else $error("data moved with clock high");
endmodule : vdr_i2c_slave
`default_nettype wire

// ### vdr_i2c_master_model.sv
// Bus master model driving open-drain clock and data lines.
// Assumes pulled-up wires resolved by the bench; moves on sys_clk falls.
`timescale 1ns/1ps
`default_nettype none
module vdr_i2c_master_model (
  input  wire logic sys_clk,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output var  logic sclOe,
  output var  logic sdaOe
);
  initial begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
  end
  // Half of a 320 ns bit
  task automatic hw();
    repeat (4) @(negedge sys_clk);
  endtask : hw
  task automatic sclHi();
    int n;
    n = 0;
    sclOe = 1'b0;
    while (sclIn !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    hw();
  endtask : sclHi
  task automatic start();
    sdaOe = 1'b0;
    hw();
    sclHi();
    sdaOe = 1'b1;
    hw();
    sclOe = 1'b1;
  endtask : start
  task automatic stop();
    sdaOe = 1'b1;
    hw();
    sclHi();
    sdaOe = 1'b0;
    hw();
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    sdaOe = ~b;
    hw();
    sclHi();
    r = sdaIn;
    sclOe = 1'b1;
  endtask : bitx
  // bytes MSB first, then ack bit
  task automatic xfer(input logic [7:0] tx, input logic ackOut,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(ackOut, ack);
  endtask : xfer
endmodule : vdr_i2c_master_model
`default_nettype wire

// ### video_decoder_i2c_register_read_tb_top.sv
// Bench for the register port: writes, two-phase reads, strap, stretch.
// Assumes the master model above and the port's own register array.
`timescale 1ns/1ps
`default_nettype none
module video_decoder_i2c_register_read_tb_top;
  import vdr_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         strap = 1'b0;
  // reference source lives outside; only its lock level is modelled
  logic         locked = 1'b1;
  logic         sSclOe, sSdaOe, mSclOe, mSdaOe, regReqValid, busy, scl, sda;
  logic         sawStretch = 1'b0;
  vdr_reg_req_s regReq;
  logic [7:0]   mem [256];
  logic [31:0]  seed = 32'hfe23d984;
  int           fails = 0;
  int           num_checks = 0;
  logic [7:0]   expWrAddr = 8'h00;
  int           stretchCyc = 0;
  int           wrSeen = 0;
  assign scl = ~(sSclOe | mSclOe);
  assign sda = ~(sSdaOe | mSdaOe);
  initial forever #20 sys_clk = ~sys_clk;
  vdr_i2c_slave #(.WAIT_CYC(20)) vdr_i2c_slave_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .sclIn(scl), .sclOut(), .sclOe(sSclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sSdaOe),
    .busAddressSelectStrap(strap), .refClkLocked(locked), .regReq(regReq),
    .regReqValid(regReqValid), .busy(busy));
  vdr_i2c_master_model vdr_i2c_master_model_i (.sys_clk(sys_clk), .sclIn(scl),
    .sdaIn(sda), .sclOe(mSclOe), .sdaOe(mSdaOe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic sendB(input logic [7:0] b, input logic expNack);
    logic [7:0] rx;
    logic       a;
    vdr_i2c_master_model_i.xfer(b, 1'b1, rx, a);
    chk({15'h0, a}, {15'h0, expNack});
  endtask : sendB
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  always @(posedge sys_clk) begin
    if (sSclOe === 1'b1) sawStretch <= 1'b1;
    if (sSclOe === 1'b1) stretchCyc <= stretchCyc + 1;
    if (regReqValid === 1'b1) wrSeen <= wrSeen + 1;
    // write request carries the expected register address and byte
    if (regReqValid === 1'b1) chk({regReq.addr, regReq.data}, {expWrAddr, mem[expWrAddr]});
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    test_done();
  end
  initial begin
    logic [7:0] base, sub, rx;
    logic       a;
    int         n0;
    for (int s = 0; s < 2; s++) begin
      @(negedge sys_clk);
      rst_b = 1'b0;
      strap = s[0];
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      strap = ~strap;
      base = s[0] ? 8'hba : 8'hb8;
      sub = s[0] ? 8'hfe : 8'(rnd()) & 8'h8f;
      vdr_i2c_master_model_i.start();
      sendB(base, 1'b0);
      sendB(sub, 1'b0);
      for (int i = 0; i < 3; i++) begin
        expWrAddr = sub + i[7:0];
        mem[expWrAddr] = 8'(rnd());
        n0 = stretchCyc;
        sendB(mem[expWrAddr], 1'b0);
        chk({15'h0, stretchCyc != n0}, {15'h0, expWrAddr <= VDR_LONG_WAIT_TOP});
      end
      vdr_i2c_master_model_i.stop();
      locked = s[0];
      fork
        begin
          repeat (300) @(negedge sys_clk);
          locked = 1'b1;
        end
      join_none
      vdr_i2c_master_model_i.start();
      sendB(base, 1'b0);
      sendB(sub, 1'b0);
      vdr_i2c_master_model_i.stop();
      vdr_i2c_master_model_i.start();
      sendB(base | 8'h01, 1'b0);
      for (int i = 0; i < 3; i++) begin
        vdr_i2c_master_model_i.xfer(8'hff, i == 2, rx, a);
        chk({8'h0, rx}, {8'h0, mem[sub + i[7:0]]});
      end
      vdr_i2c_master_model_i.stop();
      vdr_i2c_master_model_i.start();
      sendB(base ^ 8'h03, 1'b1);
      vdr_i2c_master_model_i.stop();
      $display("test strap %0d done", s);
    end
    chk(16'(wrSeen), 16'h0006);
    chk({15'h0, sawStretch}, 16'h0001);
    test_done();
  end
endmodule : video_decoder_i2c_register_read_tb_top
`default_nettype wire
